/* File: src/axm_bridge_top.sv */
// Purpose: APB-programmed fetch and load/store AXI4 masters
// Assumes: APB master holds request until pready; sync reset
// Notes: one transfer per port in flight; pready one cycle late
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "axm_params.svh"
module axm_bridge_top (
    input logic i_core_clk,
    input logic i_sys_rst,
    input logic i_clk_en,
    input logic i_fetch_bus_clk_en,
    input logic i_ls_bus_clk_en,
    input logic i_psel,
    input logic i_penable,
    input logic i_pwrite,
    input logic [11:0] i_paddr,
    input logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output axm_pkg::axm_fax_s o_fetch_aw,
    output logic o_fetch_awvalid,
    input logic i_fetch_awready,
    output axm_pkg::axm_w_s o_fetch_w,
    output logic o_fetch_wvalid,
    input logic i_fetch_wready,
    input axm_pkg::axm_fb_s i_fetch_b,
    input logic i_fetch_bvalid,
    output logic o_fetch_bready,
    output axm_pkg::axm_fax_s o_fetch_ar,
    output logic o_fetch_arvalid,
    input logic i_fetch_arready,
    input axm_pkg::axm_fr_s i_fetch_r,
    input logic i_fetch_rvalid,
    output logic o_fetch_rready,
    output axm_pkg::axm_lax_s o_ls_aw,
    output logic o_ls_awvalid,
    input logic i_ls_awready,
    output axm_pkg::axm_w_s o_ls_w,
    output logic o_ls_wvalid,
    input logic i_ls_wready,
    input axm_pkg::axm_lb_s i_ls_b,
    input logic i_ls_bvalid,
    output logic o_ls_bready,
    output axm_pkg::axm_lax_s o_ls_ar,
    output logic o_ls_arvalid,
    input logic i_ls_arready,
    input axm_pkg::axm_lr_s i_ls_r,
    input logic i_ls_rvalid,
    output logic o_ls_rready
);
    logic fetch_ce, ls_ce, apb_acc, apb_wr;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q, rd_word;
    logic [31:0] faddr_q, laddr_q, attr_q;
    logic [63:0] wdata_q;
    logic fpend_q, lpend_q, lwr_q;
    logic fbusy, lbusy;
    logic [63:0] frdata, lrdata;
    logic [1:0] fresp, lresp;
    axm_pkg::axm_lax_s ls_ax;

    // shared by write decode and error answer
    function automatic logic axm_hit(input logic [11:0] a);
        case (a)
            `AXM_OFS_CTRL, `AXM_OFS_STATUS, `AXM_OFS_FADDR, `AXM_OFS_LADDR,
            `AXM_OFS_WDLO, `AXM_OFS_WDHI, `AXM_OFS_ATTR, `AXM_OFS_FDLO,
            `AXM_OFS_FDHI, `AXM_OFS_LDLO, `AXM_OFS_LDHI: axm_hit = 1'b1;
            default: axm_hit = 1'b0;
        endcase
    endfunction : axm_hit

    assign fetch_ce = i_clk_en & i_fetch_bus_clk_en;
    assign ls_ce = i_clk_en & i_ls_bus_clk_en;
    assign apb_acc = i_psel & i_penable & ~pready_q;
    // a write lands only at the edge where pready is sampled high
    assign apb_wr = i_psel & i_penable & pready_q & i_pwrite & axm_hit(i_paddr);
    assign o_pready = pready_q;
    assign o_prdata = prdata_q;
    assign o_pslverr = pslverr_q;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pready_q <= 1'b0;
        end else if (i_clk_en) begin
            pready_q <= apb_acc;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (i_clk_en && apb_acc) begin
            prdata_q <= i_pwrite ? 32'h0000_0000 : rd_word;
            pslverr_q <= ~axm_hit(i_paddr);
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (i_paddr)
            `AXM_OFS_CTRL: rd_word[`AXM_CT_LWR] = lwr_q;
            `AXM_OFS_STATUS: begin
                rd_word[`AXM_ST_FBUSY] = fbusy | fpend_q;
                rd_word[`AXM_ST_LBUSY] = lbusy | lpend_q;
                rd_word[`AXM_ST_FRESP +: 2] = fresp;
                rd_word[`AXM_ST_LRESP +: 2] = lresp;
            end
            `AXM_OFS_FADDR: rd_word = faddr_q;
            `AXM_OFS_LADDR: rd_word = laddr_q;
            `AXM_OFS_WDLO: rd_word = wdata_q[31:0];
            `AXM_OFS_WDHI: rd_word = wdata_q[63:32];
            `AXM_OFS_ATTR: rd_word = attr_q;
            `AXM_OFS_FDLO: rd_word = frdata[31:0];
            `AXM_OFS_FDHI: rd_word = frdata[63:32];
            `AXM_OFS_LDLO: rd_word = lrdata[31:0];
            `AXM_OFS_LDHI: rd_word = lrdata[63:32];
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // configuration words; changing them mid-transfer is harmless,
    // the engines capture on start
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            faddr_q <= 32'h0000_0000;
            laddr_q <= 32'h0000_0000;
            wdata_q <= 64'h0000_0000_0000_0000;
            attr_q <= `AXM_ATTR_RST;
        end else if (i_clk_en && apb_wr) begin
            case (i_paddr)
                `AXM_OFS_FADDR: faddr_q <= i_pwdata;
                `AXM_OFS_LADDR: laddr_q <= i_pwdata;
                `AXM_OFS_WDLO: wdata_q[31:0] <= i_pwdata;
                `AXM_OFS_WDHI: wdata_q[63:32] <= i_pwdata;
                `AXM_OFS_ATTR: attr_q <= i_pwdata;
                default: attr_q <= attr_q;
            endcase
        end
    end

    // pending requests; a software set beats the engine's clear
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            fpend_q <= 1'b0;
            lpend_q <= 1'b0;
            lwr_q <= 1'b0;
        end else if (i_clk_en) begin
            if (apb_wr && i_paddr == `AXM_OFS_CTRL && i_pwdata[`AXM_CT_FGO]) begin
                fpend_q <= 1'b1;
            end else if (fpend_q && !fbusy && fetch_ce) begin
                // clear only when the engine takes it, so go while busy stays queued
                fpend_q <= 1'b0;
            end
            if (apb_wr && i_paddr == `AXM_OFS_CTRL && i_pwdata[`AXM_CT_LGO]) begin
                lpend_q <= 1'b1;
                lwr_q <= i_pwdata[`AXM_CT_LWR];
            end else if (lpend_q && !lbusy && ls_ce) begin
                lpend_q <= 1'b0;
            end
        end
    end

    axm_fetch_master u_fetch (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_bus_clk_en(i_fetch_bus_clk_en),
        .i_start(fpend_q & ~fbusy),
        .i_addr(faddr_q),
        .i_tag(attr_q[`AXM_AT_FTAG +: axm_pkg::fetch_tag_width_param]),
        .o_aw(o_fetch_aw),
        .o_awvalid(o_fetch_awvalid),
        .o_w(o_fetch_w),
        .o_wvalid(o_fetch_wvalid),
        .o_bready(o_fetch_bready),
        .o_ar(o_fetch_ar),
        .o_arvalid(o_fetch_arvalid),
        .i_arready(i_fetch_arready),
        .i_r(i_fetch_r),
        .i_rvalid(i_fetch_rvalid),
        .o_rready(o_fetch_rready),
        .o_busy(fbusy),
        .o_rdata(frdata),
        .o_rresp(fresp)
    );

    axm_ls_master u_ls (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_bus_clk_en(i_ls_bus_clk_en),
        .i_start(lpend_q & ~lbusy),
        .i_write(lwr_q),
        .i_addr(laddr_q),
        .i_wdata(wdata_q),
        .i_strb(attr_q[`AXM_AT_STRB +: 8]),
        .i_size(attr_q[`AXM_AT_SIZE +: 3]),
        .i_cache(attr_q[`AXM_AT_CACHE +: 4]),
        .i_tag(attr_q[`AXM_AT_LTAG +: axm_pkg::loadstore_tag_width_param]),
        .o_ax(ls_ax),
        .o_awvalid(o_ls_awvalid),
        .i_awready(i_ls_awready),
        .o_w(o_ls_w),
        .o_wvalid(o_ls_wvalid),
        .i_wready(i_ls_wready),
        .i_b(i_ls_b),
        .i_bvalid(i_ls_bvalid),
        .o_bready(o_ls_bready),
        .o_arvalid(o_ls_arvalid),
        .i_arready(i_ls_arready),
        .i_r(i_ls_r),
        .i_rvalid(i_ls_rvalid),
        .o_rready(o_ls_rready),
        .o_busy(lbusy),
        .o_rdata(lrdata),
        .o_resp(lresp)
    );

    assign o_ls_aw = ls_ax;
    assign o_ls_ar = ls_ax;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_fetch_take;
        fpend_q && !fbusy && fetch_ce;
    endsequence
    sequence s_ls_wr_take;
        lpend_q && !lbusy && ls_ce && lwr_q;
    endsequence

    property p_fetch_wr_off;
        !o_fetch_wvalid && o_fetch_w == '0;
    endproperty
    a_fetch_wr_off: assert property (p_fetch_wr_off) else $error("fetch wvalid high");
    property p_fetch_b_off;
        !o_fetch_bready;
    endproperty
    a_fetch_b_off: assert property (p_fetch_b_off) else $error("fetch bready high");
    property p_fetch_aw_off;
        !o_fetch_awvalid && o_fetch_aw == '0;
    endproperty
    a_fetch_aw_off: assert property (p_fetch_aw_off) else $error("fetch aw active");
    property p_fetch_tied;
        (i_fetch_bvalid || i_fetch_wready || i_fetch_awready) |-> !o_fetch_bready;
    endproperty
    a_fetch_tied: assert property (p_fetch_tied) else $error("fetch write side moved");
    property p_len_zero;
        (o_fetch_arvalid |-> o_fetch_ar.len == 8'h00)
        and ((o_ls_arvalid || o_ls_awvalid) |-> ls_ax.len == 8'h00);
    endproperty
    a_len_zero: assert property (p_len_zero) else $error("burst length not zero");
    property p_fetch_attr;
        o_fetch_arvalid |-> o_fetch_ar.size == 3'h3 && o_fetch_ar.cache == 4'hf
            && o_fetch_ar.prot == 3'h4 && o_fetch_ar.qos == 4'h0;
    endproperty
    a_fetch_attr: assert property (p_fetch_attr) else $error("fetch attribute wrong");
    property p_burst_lock;
        (o_fetch_arvalid || o_ls_arvalid || o_ls_awvalid) |->
            o_fetch_ar.burst == 2'h1 && ls_ax.burst == 2'h1
            && !o_fetch_ar.lock && !ls_ax.lock;
    endproperty
    a_burst_lock: assert property (p_burst_lock) else $error("burst or lock wrong");
    property p_ls_prot_qos;
        (o_ls_arvalid || o_ls_awvalid) |-> ls_ax.prot == 3'h0 && o_ls_aw.qos == 4'h0;
    endproperty
    a_ls_prot_qos: assert property (p_ls_prot_qos) else $error("ls prot or qos");
    property p_fetch_issue;
        s_fetch_take |=> o_fetch_arvalid && o_fetch_ar.addr == $past(faddr_q)
            && o_fetch_ar.id == $past(attr_q[18:16]);
    endproperty
    a_fetch_issue: assert property (p_fetch_issue) else $error("fetch issue wrong");
    property p_ls_write_issue;
        s_ls_wr_take |=> o_ls_awvalid && o_ls_wvalid && o_ls_w.last
            && o_ls_w.strb == $past(attr_q[7:0]) && o_ls_w.data == $past(wdata_q);
    endproperty
    a_ls_write_issue: assert property (p_ls_write_issue) else $error("ls write issue");
    property p_ar_hold;
        o_fetch_arvalid && !(i_fetch_arready && fetch_ce) |=>
            o_fetch_arvalid && $stable(o_fetch_ar);
    endproperty
    a_ar_hold: assert property (p_ar_hold) else $error("fetch ar dropped");
    property p_w_hold;
        o_ls_wvalid && !(i_ls_wready && ls_ce) |=> o_ls_wvalid && $stable(o_ls_w);
    endproperty
    a_w_hold: assert property (p_w_hold) else $error("ls w dropped");
    property p_fetch_stall;
        !i_fetch_bus_clk_en && !o_fetch_arvalid |=> !o_fetch_arvalid;
    endproperty
    a_fetch_stall: assert property (p_fetch_stall) else $error("fetch moved while gated");
    property p_fetch_rready;
        o_fetch_arvalid && i_fetch_arready && fetch_ce |=> o_fetch_rready [*1] ##0 fbusy;
    endproperty
    a_fetch_rready: assert property (p_fetch_rready) else $error("no rready after ar");
endmodule : axm_bridge_top

/* File: src/axm_fetch_master.sv */
// Purpose: read-only fetch AXI4 master engine
// Assumes: i_start held until o_busy rises
// Notes: one outstanding read
`timescale 1ns/100ps
`include "axm_params.svh"
module axm_fetch_master (
    input logic i_core_clk,
    input logic i_sys_rst,
    input logic i_clk_en,
    input logic i_bus_clk_en,
    input logic i_start,
    input logic [`AXM_ADDR_W-1:0] i_addr,
    input axm_pkg::axm_ftag_t i_tag,
    output axm_pkg::axm_fax_s o_aw,
    output logic o_awvalid,
    output axm_pkg::axm_w_s o_w,
    output logic o_wvalid,
    output logic o_bready,
    output axm_pkg::axm_fax_s o_ar,
    output logic o_arvalid,
    input logic i_arready,
    input axm_pkg::axm_fr_s i_r,
    input logic i_rvalid,
    output logic o_rready,
    output logic o_busy,
    output logic [`AXM_DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp
);
    axm_pkg::axm_state_e st_q;
    logic ce;
    logic [`AXM_ADDR_W-1:0] addr_q;
    axm_pkg::axm_ftag_t tag_q;

    assign ce = i_clk_en & i_bus_clk_en;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st_q <= axm_pkg::ST_IDLE;
            addr_q <= '0;
            tag_q <= '0;
        end else if (ce) begin
            case (st_q)
                axm_pkg::ST_IDLE: begin
                    if (i_start) begin
                        st_q <= axm_pkg::ST_ADDR;
                        addr_q <= i_addr;
                        tag_q <= i_tag;
                    end
                end
                axm_pkg::ST_ADDR: if (i_arready) st_q <= axm_pkg::ST_DATA;
                axm_pkg::ST_DATA: if (i_rvalid) st_q <= axm_pkg::ST_IDLE;
                default: st_q <= axm_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_rdata <= '0;
            o_rresp <= 2'h0;
        end else if (ce && st_q == axm_pkg::ST_DATA && i_rvalid) begin
            o_rdata <= i_r.data;
            o_rresp <= i_r.resp;
        end
    end

    // write side exists only as tied-off wires
    assign o_awvalid = 1'b0;
    assign o_wvalid = 1'b0;
    assign o_bready = 1'b0;
    assign o_aw = '0;
    assign o_w = '0;
    assign o_arvalid = (st_q == axm_pkg::ST_ADDR);
    assign o_rready = (st_q == axm_pkg::ST_DATA);
    assign o_busy = (st_q != axm_pkg::ST_IDLE);
    assign o_ar = '{id: tag_q, addr: addr_q, len: `AXM_LEN_SINGLE,
                    size: `AXM_SIZE_8B, burst: `AXM_BURST_INCR,
                    lock: `AXM_LOCK_NORMAL, cache: `AXM_FETCH_CACHE,
                    prot: `AXM_FETCH_PROT, qos: `AXM_QOS_NONE,
                    region: `AXM_REGION_NONE};
endmodule : axm_fetch_master

/* File: src/axm_ls_master.sv */
// Purpose: load/store AXI4 master engine, single beats
// Assumes: i_start held until o_busy rises
// Notes: aw and w issued together, either may win
`timescale 1ns/100ps
`include "axm_params.svh"
module axm_ls_master (
    input logic i_core_clk,
    input logic i_sys_rst,
    input logic i_clk_en,
    input logic i_bus_clk_en,
    input logic i_start,
    input logic i_write,
    input logic [`AXM_ADDR_W-1:0] i_addr,
    input logic [`AXM_DATA_W-1:0] i_wdata,
    input logic [`AXM_STRB_W-1:0] i_strb,
    input logic [2:0] i_size,
    input logic [3:0] i_cache,
    input axm_pkg::axm_ltag_t i_tag,
    output axm_pkg::axm_lax_s o_ax,
    output logic o_awvalid,
    input logic i_awready,
    output axm_pkg::axm_w_s o_w,
    output logic o_wvalid,
    input logic i_wready,
    input axm_pkg::axm_lb_s i_b,
    input logic i_bvalid,
    output logic o_bready,
    output logic o_arvalid,
    input logic i_arready,
    input axm_pkg::axm_lr_s i_r,
    input logic i_rvalid,
    output logic o_rready,
    output logic o_busy,
    output logic [`AXM_DATA_W-1:0] o_rdata,
    output logic [1:0] o_resp
);
    axm_pkg::axm_state_e st_q;
    logic ce, aw_done_q, w_done_q, aw_ok, w_ok;
    logic [`AXM_ADDR_W-1:0] addr_q;
    logic [`AXM_DATA_W-1:0] wdata_q;
    logic [`AXM_STRB_W-1:0] strb_q;
    logic [2:0] size_q;
    logic [3:0] cache_q;
    axm_pkg::axm_ltag_t tag_q;

    assign ce = i_clk_en & i_bus_clk_en;
    assign aw_ok = aw_done_q | i_awready;
    assign w_ok = w_done_q | i_wready;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st_q <= axm_pkg::ST_IDLE;
            aw_done_q <= 1'b0;
            w_done_q <= 1'b0;
        end else if (ce) begin
            case (st_q)
                axm_pkg::ST_IDLE: begin
                    if (i_start) st_q <= i_write ? axm_pkg::ST_WRITE : axm_pkg::ST_ADDR;
                end
                axm_pkg::ST_ADDR: if (i_arready) st_q <= axm_pkg::ST_DATA;
                axm_pkg::ST_DATA: if (i_rvalid) st_q <= axm_pkg::ST_IDLE;
                axm_pkg::ST_WRITE: begin
                    // either channel may be accepted first; keep the other up
                    aw_done_q <= aw_ok & ~w_ok;
                    w_done_q <= w_ok & ~aw_ok;
                    if (aw_ok && w_ok) st_q <= axm_pkg::ST_BRESP;
                end
                axm_pkg::ST_BRESP: if (i_bvalid) st_q <= axm_pkg::ST_IDLE;
                default: st_q <= axm_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            addr_q <= '0;
            wdata_q <= '0;
            strb_q <= '0;
            size_q <= 3'h0;
            cache_q <= 4'h0;
            tag_q <= '0;
        end else if (ce && st_q == axm_pkg::ST_IDLE && i_start) begin
            addr_q <= i_addr;
            wdata_q <= i_wdata;
            strb_q <= i_strb;
            size_q <= i_size;
            cache_q <= i_cache;
            tag_q <= i_tag;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_rdata <= '0;
            o_resp <= 2'h0;
        end else if (ce && st_q == axm_pkg::ST_DATA && i_rvalid) begin
            o_rdata <= i_r.data;
            o_resp <= i_r.resp;
        end else if (ce && st_q == axm_pkg::ST_BRESP && i_bvalid) begin
            o_resp <= i_b.resp;
        end
    end

    assign o_awvalid = (st_q == axm_pkg::ST_WRITE) & ~aw_done_q;
    assign o_wvalid = (st_q == axm_pkg::ST_WRITE) & ~w_done_q;
    assign o_bready = (st_q == axm_pkg::ST_BRESP);
    assign o_arvalid = (st_q == axm_pkg::ST_ADDR);
    assign o_rready = (st_q == axm_pkg::ST_DATA);
    assign o_busy = (st_q != axm_pkg::ST_IDLE);
    assign o_w = '{data: wdata_q, strb: strb_q, last: 1'b1};
    assign o_ax = '{id: tag_q, addr: addr_q, len: `AXM_LEN_SINGLE,
                    size: size_q, burst: `AXM_BURST_INCR,
                    lock: `AXM_LOCK_NORMAL, cache: cache_q,
                    prot: `AXM_LS_PROT, qos: `AXM_QOS_NONE,
                    region: `AXM_REGION_NONE};
endmodule : axm_ls_master

/* File: src/axm_params.svh */
// Purpose: constants for the fetch and load/store AXI4 masters
// Assumes: included by the package and every module but the slave model
// Notes: offsets are APB byte addresses
`ifndef AXM_PARAMS_SVH
`define AXM_PARAMS_SVH
`define AXM_ADDR_W 32
`define AXM_DATA_W 64
`define AXM_STRB_W 8
`define AXM_FETCH_TAG_W 3
`define AXM_LS_TAG_W 4
`define AXM_LEN_SINGLE 8'h00
`define AXM_SIZE_8B 3'h3
`define AXM_BURST_INCR 2'h1
`define AXM_LOCK_NORMAL 1'b0
`define AXM_FETCH_CACHE 4'hf
`define AXM_FETCH_PROT 3'h4
`define AXM_LS_PROT 3'h0
`define AXM_QOS_NONE 4'h0
`define AXM_REGION_NONE 4'h0
`define AXM_OFS_CTRL 12'h000
`define AXM_OFS_STATUS 12'h004
`define AXM_OFS_FADDR 12'h008
`define AXM_OFS_LADDR 12'h00c
`define AXM_OFS_WDLO 12'h010
`define AXM_OFS_WDHI 12'h014
`define AXM_OFS_ATTR 12'h018
`define AXM_OFS_FDLO 12'h01c
`define AXM_OFS_FDHI 12'h020
`define AXM_OFS_LDLO 12'h024
`define AXM_OFS_LDHI 12'h028
`define AXM_CT_FGO 0
`define AXM_CT_LGO 1
`define AXM_CT_LWR 2
`define AXM_ST_FBUSY 0
`define AXM_ST_LBUSY 1
`define AXM_ST_FRESP 4
`define AXM_ST_LRESP 8
`define AXM_AT_STRB 0
`define AXM_AT_SIZE 8
`define AXM_AT_CACHE 12
`define AXM_AT_FTAG 16
`define AXM_AT_LTAG 20
`define AXM_ATTR_RST 32'h0000_03ff
`endif

/* File: src/axm_pkg.sv */
// Purpose: types for the fetch and load/store AXI4 masters
// Assumes: axm_params.svh holds the numbers
// Notes: tag width differs per port, hence two struct sets
`include "axm_params.svh"
package axm_pkg;
    localparam int fetch_tag_width_param = `AXM_FETCH_TAG_W;
    localparam int loadstore_tag_width_param = `AXM_LS_TAG_W;
    typedef logic [fetch_tag_width_param-1:0] axm_ftag_t;
    typedef logic [loadstore_tag_width_param-1:0] axm_ltag_t;
    typedef struct packed {
        axm_ftag_t id;
        logic [`AXM_ADDR_W-1:0] addr;
        logic [7:0] len;
        logic [2:0] size;
        logic [1:0] burst;
        logic lock;
        logic [3:0] cache;
        logic [2:0] prot;
        logic [3:0] qos;
        logic [3:0] region;
    } axm_fax_s;
    typedef struct packed {
        axm_ltag_t id;
        logic [`AXM_ADDR_W-1:0] addr;
        logic [7:0] len;
        logic [2:0] size;
        logic [1:0] burst;
        logic lock;
        logic [3:0] cache;
        logic [2:0] prot;
        logic [3:0] qos;
        logic [3:0] region;
    } axm_lax_s;
    typedef struct packed {
        logic [`AXM_DATA_W-1:0] data;
        logic [`AXM_STRB_W-1:0] strb;
        logic last;
    } axm_w_s;
    typedef struct packed {
        axm_ftag_t id;
        logic [`AXM_DATA_W-1:0] data;
        logic [1:0] resp;
        logic last;
    } axm_fr_s;
    typedef struct packed {
        axm_ltag_t id;
        logic [`AXM_DATA_W-1:0] data;
        logic [1:0] resp;
        logic last;
    } axm_lr_s;
    typedef struct packed {
        axm_ftag_t id;
        logic [1:0] resp;
    } axm_fb_s;
    typedef struct packed {
        axm_ltag_t id;
        logic [1:0] resp;
    } axm_lb_s;
    typedef enum {ST_IDLE, ST_ADDR, ST_DATA, ST_WRITE, ST_BRESP} axm_state_e;
endpackage : axm_pkg

/* File: testbench/axm_bridge_top_tb_top.sv */
// Purpose: self-checking bench for the bridge
// Assumes: slave model stalls at random
// Notes: read data echoes request fields
`timescale 1ns/100ps
`include "axm_params.svh"
module axm_bridge_top_tb_top;
    logic i_core_clk, i_sys_rst, i_clk_en, i_fetch_bus_clk_en, i_ls_bus_clk_en, i_psel;
    logic i_penable, i_pwrite, o_pready, o_pslverr, o_fetch_awvalid, i_fetch_awready;
    logic o_fetch_wvalid, i_fetch_wready, i_fetch_bvalid, o_fetch_bready, o_fetch_arvalid;
    logic i_fetch_arready, i_fetch_rvalid, o_fetch_rready, o_ls_awvalid, i_ls_awready;
    logic o_ls_wvalid, i_ls_wready, i_ls_bvalid, o_ls_bready, o_ls_arvalid, i_ls_arready;
    logic i_ls_rvalid, o_ls_rready;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd, fa, la, at;
    logic [63:0] wd;
    axm_pkg::axm_fax_s o_fetch_aw, o_fetch_ar;
    axm_pkg::axm_lax_s o_ls_aw, o_ls_ar;
    axm_pkg::axm_w_s o_fetch_w, o_ls_w;
    axm_pkg::axm_fb_s i_fetch_b;
    axm_pkg::axm_lb_s i_ls_b;
    axm_pkg::axm_fr_s i_fetch_r;
    axm_pkg::axm_lr_s i_ls_r;
    int error_cnt = 0;
    int num_checks = 0;
    assign {i_fetch_awready, i_fetch_wready, i_fetch_bvalid, i_fetch_b} = '1;
    axm_bridge_top DUT (.*);
    axm_slave_model PRT (.*);
    initial begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do @(posedge i_core_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        {i_psel, i_penable} <= 2'b00;
    endtask : apb
    task automatic go(input logic [31:0] c);
        apb(1'b1, `AXM_OFS_CTRL, c);
        do apb(1'b0, `AXM_OFS_STATUS, 32'h0); while (rd[1:0] !== 2'b00);
    endtask : go
    // slow ports by dropping each bus enable a quarter of the time
    always @(posedge i_core_clk) begin
        {i_fetch_bus_clk_en, i_ls_bus_clk_en} <= {$urandom % 4 != 0, $urandom % 4 != 0};
    end
    always @(negedge i_core_clk) chk({o_fetch_awvalid, o_fetch_wvalid, o_fetch_bready}, 0);
    initial begin
        repeat (9000) @(posedge i_core_clk);
        error_cnt++;
        complete_run();
    end
    initial begin
        void'($urandom(27));
        {i_sys_rst, i_clk_en, i_fetch_bus_clk_en, i_ls_bus_clk_en} = 4'hf;
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        repeat (4) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        repeat (8) begin
            {fa, la, wd} = {$urandom, $urandom, $urandom, $urandom};
            at = $urandom & 32'h00f7_f7ff;
            apb(1'b1, `AXM_OFS_ATTR, at);
            apb(1'b1, `AXM_OFS_FADDR, fa);
            apb(1'b1, `AXM_OFS_LADDR, la);
            apb(1'b1, `AXM_OFS_WDLO, wd[31:0]);
            apb(1'b1, `AXM_OFS_WDHI, wd[63:32]);
            go(32'h7);
            chk({rd[9:8], rd[5:4]}, {at[1:0], fa[3:2]});
            apb(1'b0, `AXM_OFS_FDLO, 32'h0);
            chk(rd, {14'h3, 2'h1, 1'b0, 4'hf, 3'h4, 8'h00});
            go(32'h2);
            chk(rd[9:8], la[3:2]);
            apb(1'b0, `AXM_OFS_LDLO, 32'h0);
            chk(rd, wd[31:0] ^ {11'h0, at[10:8], 2'h1, 1'b0, at[15:12], 11'h0});
            apb(1'b0, `AXM_OFS_LDHI, 32'h0);
            chk(rd, wd[63:32] ^ la);
        end
        apb(1'b0, 12'h0fc, 32'h0);
        chk({o_pslverr, rd}, {1'b1, 32'h0});
        complete_run();
    end
endmodule : axm_bridge_top_tb_top

/* File: testbench/axm_slave_model.sv */
// Purpose: far-side AXI4 slave model
// Assumes: moves only on edges with its port enable high
// Notes: aw and w share one ready; data echoes the request
`timescale 1ns/100ps
module axm_slave_model (
    input wire logic i_core_clk, i_sys_rst, i_fetch_bus_clk_en, i_ls_bus_clk_en,
    input wire axm_pkg::axm_fax_s o_fetch_ar,
    input wire axm_pkg::axm_lax_s o_ls_ar,
    input wire axm_pkg::axm_w_s o_ls_w,
    input wire logic o_fetch_arvalid, o_fetch_rready, o_ls_wvalid, o_ls_bready,
    input wire logic o_ls_arvalid, o_ls_rready,
    output axm_pkg::axm_fr_s i_fetch_r,
    output axm_pkg::axm_lr_s i_ls_r,
    output axm_pkg::axm_lb_s i_ls_b,
    output logic i_fetch_arready, i_fetch_rvalid, i_ls_awready, i_ls_wready,
    output logic i_ls_bvalid, i_ls_arready, i_ls_rvalid
);
    logic [63:0] wd;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            {i_fetch_arready, i_fetch_rvalid, i_ls_awready, i_ls_wready} <= 4'h0;
            {i_ls_bvalid, i_ls_arready, i_ls_rvalid, wd} <= '0;
        end else begin
            if (i_fetch_bus_clk_en) begin
                i_fetch_arready <= 1'($urandom);
                if (o_fetch_arvalid && i_fetch_arready) begin
                    i_fetch_r <= {o_fetch_ar.id, o_fetch_ar.addr, 3'h0, o_fetch_ar[28:0],
                        o_fetch_ar.addr[3:2], 1'b1};
                    i_fetch_rvalid <= 1'b1;
                end else if (o_fetch_rready) begin
                    i_fetch_rvalid <= 1'b0;
                end
            end
            if (i_ls_bus_clk_en) begin
                {i_ls_awready, i_ls_wready, i_ls_arready} <= {{2{1'($urandom)}}, 1'($urandom)};
                if (o_ls_wvalid && i_ls_wready) begin
                    wd <= o_ls_w.data;
                    i_ls_b <= {o_ls_ar.id, o_ls_w.strb[1:0]};
                    i_ls_bvalid <= 1'b1;
                end else if (o_ls_bready) begin
                    i_ls_bvalid <= 1'b0;
                end
                if (o_ls_arvalid && i_ls_arready) begin
                    i_ls_r <= {o_ls_ar.id, wd ^ {o_ls_ar.addr, 3'h0, o_ls_ar[28:0]},
                        o_ls_ar.addr[3:2], 1'b1};
                    i_ls_rvalid <= 1'b1;
                end else if (o_ls_rready) begin
                    i_ls_rvalid <= 1'b0;
                end
            end
        end
    end
endmodule : axm_slave_model
